// >>> core/slmrc_top.sv
// Top: reset and strap sampling, boot sequencing, oscillator config, loops
// Operation
// [R1] Board holds device reset low at least 50 us.
// [R2] Reset low until oscillator runs, or pulsed again after.
// [R3] Board holds straps steady 2 ms after reset release; sampled then.
// [R4] With memory load, clocks stable within 100 ms of release; code times each load attempt for 100 ms from its own start.
// [R5] Failed load retried up to twice; third failure halts device.
// [R6] Without memory load, clocks stable within 10 ms of release.
// [R7] Internal timing uses the oscillator edge chosen by edge-select bit.
// [R8] Three-bit code selects one of eight nominal oscillator frequencies.
// [R9] Frequency code comes from straps, writable through config register.
// [R10] 24-bit nominal frequency trim, range plus or minus 741 ppm.
// [R11] Each loop has a 4-bit mode control field with fixed codes.
// [R12] Per-loop 4-bit status always shows the present mode.
// [R13] A mode change sets that loop's change flag.
// [R14] Interrupt while change flag and mask bit are one; masks reset zero.
// [R15] Host interface straps set the default interface selection.
// [R16] Automatic mode goes to locked once the lock flag is one.
// [R17] Forced modes hold regardless of input events until rewritten.
// [R18] Change flag sticky until cleared; interrupt drops on clear or mask.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module slmrc_top
	import slmrc_pkg::*;
#(
	parameter int STRAP_CYCLES  = STRAP_CYC,
	parameter int NOLOAD_CYCLES = NOLOAD_CYC,
	parameter int LOAD_CYCLES   = LOAD_CYC
) (
	input  wire logic        clk,
	input  wire logic        device_reset_low,
	input  wire logic        sys_osc_input,
	input  wire logic [2:0]  osc_freq_strap,
	input  wire logic [1:0]  host_if_strap,
	input  wire logic        line_rate_strap,
	input  wire logic        load_done,
	input  wire logic        load_fail,
	input  wire logic        l1_selected,
	input  wire logic        l1_lock,
	input  wire logic        l1_lost,
	input  wire logic        l2_selected,
	input  wire logic        l2_lock,
	input  wire logic        l2_lost,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata_q,
	output logic             load_start_q,
	output logic             clocks_stable_q,
	output logic             halted_q,
	output logic             osc_tick_q,
	output logic [15:0]      osc_khz_q,
	output logic [23:0]      trim_q,
	output logic [3:0]       l1_mode_q,
	output logic [3:0]       l2_mode_q,
	output logic             irq_q
);
	logic        rst_meta_q, rst_n;
	logic [31:0] cnt_q;
	logic [1:0]  retry_q;
	slmrc_boot_t boot_q;
	logic        strap_done_q;
	logic [2:0]  osc_freq_config_q;
	logic        sel_a_q;
	logic [1:0]  host_if_config_q;
	logic        line_rate_q;
	logic [3:0]  loop1_mode_ctrl_q, loop2_mode_ctrl_q;
	logic [1:0]  loop_mode_change_flag_q, mask_q;
	logic [3:0]  m1, m2;
	logic        c1, c2, tick;
	logic        wr_osc, wr_int;

	// Reset release through two flip-flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge device_reset_low) begin
		if (!device_reset_low) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	assign wr_osc = reg_wr && reg_addr == ADDR_OSC_CFG;
	assign wr_int = reg_wr && reg_addr == ADDR_INT_STS;

	// Boot sequencer: strap window, optional memory load with retries
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_q <= SLMRC_BOOT_STRAP;
			cnt_q <= 32'h0;
			retry_q <= 2'h0;
			load_start_q <= 1'b0;
			clocks_stable_q <= 1'b0;
			halted_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else begin
			load_start_q <= 1'b0;
			cnt_q <= cnt_q + 32'h1;
			case (boot_q)
			SLMRC_BOOT_STRAP: begin
				// Straps are only trusted at the end of the hold window
				if (cnt_q >= 32'(STRAP_CYCLES - 1)) begin // [R3]
					strap_done_q <= 1'b1;
					if (host_if_strap == HOST_TWI_MASTER) begin
						boot_q <= SLMRC_BOOT_LOAD;
					end else begin
						boot_q <= SLMRC_BOOT_SETTLE;
					end
				end
			end
			SLMRC_BOOT_LOAD: begin
				load_start_q <= 1'b1;
				cnt_q <= 32'h0;
				boot_q <= SLMRC_BOOT_WAIT;
			end
			SLMRC_BOOT_WAIT: begin
				if (load_done) begin
					boot_q <= SLMRC_BOOT_READY;
					clocks_stable_q <= 1'b1; // [R4]
				end else if (load_fail || cnt_q >= 32'(LOAD_CYCLES - 1)) begin
					if (retry_q == 2'(MAX_RETRY)) begin
						boot_q <= SLMRC_BOOT_HALT; // [R5]
						halted_q <= 1'b1;
					end else begin
						retry_q <= retry_q + 2'h1; // [R5]
						boot_q <= SLMRC_BOOT_LOAD;
					end
				end
			end
			SLMRC_BOOT_SETTLE: begin
				// Counter still runs from release, so this bounds total time
				if (cnt_q >= 32'(NOLOAD_CYCLES - 1)) begin // [R6]
					boot_q <= SLMRC_BOOT_READY;
					clocks_stable_q <= 1'b1;
				end
			end
			SLMRC_BOOT_READY: cnt_q <= cnt_q;
			SLMRC_BOOT_HALT:  cnt_q <= cnt_q;
			default: boot_q <= SLMRC_BOOT_HALT;
			endcase
		end
	end

	// Oscillator config: strap copy at window end, software may override
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_freq_config_q <= 3'h0;
			sel_a_q <= 1'b0;
			host_if_config_q <= 2'h0;
			line_rate_q <= 1'b0;
		end else if (boot_q == SLMRC_BOOT_STRAP && !strap_done_q
			&& cnt_q >= 32'(STRAP_CYCLES - 1)) begin
			osc_freq_config_q <= osc_freq_strap; // [R9]
			host_if_config_q <= host_if_strap; // [R15]
			line_rate_q <= line_rate_strap;
		end else begin
			if (wr_osc) begin
				osc_freq_config_q <= reg_wdata[2:0]; // [R9]
				sel_a_q <= reg_wdata[SEL_A_BIT]; // [R7]
			end
			if (reg_wr && reg_addr == ADDR_HOST_IF) begin
				host_if_config_q <= reg_wdata[1:0];
			end
		end
	end

	// Trim and loop controls; forced codes stay until rewritten
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_q <= TRIM_RST;
			loop1_mode_ctrl_q <= MODE_AUTO;
			loop2_mode_ctrl_q <= MODE_AUTO;
			mask_q <= MASK_RST; // [R14]
		end else if (reg_wr) begin
			case (reg_addr)
			ADDR_TRIM:     trim_q <= reg_wdata[23:0]; // [R10]
			ADDR_L1_CTRL:  loop1_mode_ctrl_q <= reg_wdata[3:0]; // [R11]
			ADDR_L2_CTRL:  loop2_mode_ctrl_q <= reg_wdata[3:0]; // [R11]
			ADDR_INT_MASK: mask_q <= reg_wdata[1:0];
			default: ;
			endcase
		end
	end

	// Nominal frequency follows the code; trim applied downstream
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_khz_q <= 16'h0;
		end else begin
			osc_khz_q <= OSC_KHZ[osc_freq_config_q]; // [R8]
		end
	end

	slmrc_edge_sel u_edge (
		.clk           (clk),
		.rst_n         (rst_n),
		.sys_osc_input (sys_osc_input),
		.sel_a         (sel_a_q),
		.tick_q        (tick)
	);

	slmrc_loop_mode u_loop1 (
		.clk         (clk),
		.rst_n       (rst_n),
		.ctrl        (loop1_mode_ctrl_q),
		.in_selected (l1_selected),
		.in_lock     (l1_lock),
		.in_lost     (l1_lost),
		.mode_q      (m1),
		.change_q    (c1)
	);

	slmrc_loop_mode u_loop2 (
		.clk         (clk),
		.rst_n       (rst_n),
		.ctrl        (loop2_mode_ctrl_q),
		.in_selected (l2_selected),
		.in_lock     (l2_lock),
		.in_lost     (l2_lost),
		.mode_q      (m2),
		.change_q    (c2)
	);

	// Sticky change flags: set beats a simultaneous write-one clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_mode_change_flag_q <= 2'h0;
		end else begin
			loop_mode_change_flag_q <= (loop_mode_change_flag_q
				& ~(wr_int ? reg_wdata[1:0] : 2'h0)) | {c2, c1}; // [R13] [R18]
		end
	end

	// Registered outputs; irq lags flag or mask by one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
			osc_tick_q <= 1'b0;
			l1_mode_q <= MODE_FREERUN;
			l2_mode_q <= MODE_FREERUN;
		end else begin
			irq_q <= |(loop_mode_change_flag_q & mask_q); // [R14] [R18]
			osc_tick_q <= tick;
			l1_mode_q <= m1; // [R12]
			l2_mode_q <= m2; // [R12]
		end
	end

	// Read port: data in the cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
			ADDR_OSC_CFG:  reg_rdata_q <= {28'h0, sel_a_q, osc_freq_config_q};
			ADDR_TRIM:     reg_rdata_q <= {8'h0, trim_q};
			ADDR_HOST_IF:  reg_rdata_q <= {30'h0, host_if_config_q};
			ADDR_L1_CTRL:  reg_rdata_q <= {28'h0, loop1_mode_ctrl_q};
			ADDR_L2_CTRL:  reg_rdata_q <= {28'h0, loop2_mode_ctrl_q};
			ADDR_MODE_STS: reg_rdata_q <= {24'h0, m2, m1}; // [R12]
			ADDR_INT_STS:  reg_rdata_q <= {30'h0, loop_mode_change_flag_q};
			ADDR_INT_MASK: reg_rdata_q <= {30'h0, mask_q};
			ADDR_BOOT_STS: reg_rdata_q <= {27'h0, retry_q, halted_q,
				clocks_stable_q, strap_done_q};
			ADDR_STRAP:    reg_rdata_q <= {31'h0, line_rate_q};
			default:       reg_rdata_q <= 32'h0;
			endcase
		end else begin
			reg_rdata_q <= 32'h0;
		end
	end

	// Interrupt follows flag and mask one cycle later, both ways
	irq_gate_a: assert property (@(posedge clk) // [R14]
		disable iff (!rst_n)
		(|(loop_mode_change_flag_q & mask_q)) |=> irq_q)
		else $error("irq not raised by flag and mask");
	irq_drop_a: assert property (@(posedge clk) // [R18]
		disable iff (!rst_n)
		!(|(loop_mode_change_flag_q & mask_q)) |=> !irq_q)
		else $error("irq not withdrawn");
	flag_sticky_a: assert property (@(posedge clk) // [R18]
		disable iff (!rst_n)
		(loop_mode_change_flag_q[0] && !(wr_int && reg_wdata[0]))
		|=> loop_mode_change_flag_q[0])
		else $error("change flag dropped without clear");
	flag_set_a: assert property (@(posedge clk) // [R13]
		disable iff (!rst_n) c1 |=> loop_mode_change_flag_q[0])
		else $error("change flag not set");
	halt_retry_a: assert property (@(posedge clk) // [R5]
		disable iff (!rst_n) $rose(halted_q) |-> retry_q == 2'(MAX_RETRY))
		else $error("halt before two retries");
	strap_take_a: assert property (@(posedge clk) // [R9]
		disable iff (!rst_n)
		$rose(strap_done_q) |-> osc_freq_config_q == $past(osc_freq_strap))
		else $error("strap not sampled");
	stable_noload_a: assert property (@(posedge clk) // [R6]
		disable iff (!rst_n)
		(boot_q == SLMRC_BOOT_SETTLE) |-> cnt_q < 32'(NOLOAD_CYCLES))
		else $error("stable clocks late");
	cover_irq: cover property (@(posedge clk) disable iff (!rst_n) irq_q);
	cover_halt: cover property (@(posedge clk) disable iff (!rst_n)
		halted_q);
	cover_stable: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(clocks_stable_q));
endmodule
`default_nettype wire

// >>> core/slmrc_pkg.sv
// Package: register map, encodings and timing counts of the loop mode and reset control
package slmrc_pkg;
	localparam int CLK_MHZ = 250;
	// Register indices on the plain port
	localparam logic [3:0] ADDR_OSC_CFG   = 4'h0;
	localparam logic [3:0] ADDR_TRIM      = 4'h1;
	localparam logic [3:0] ADDR_HOST_IF   = 4'h2;
	localparam logic [3:0] ADDR_L1_CTRL   = 4'h3;
	localparam logic [3:0] ADDR_L2_CTRL   = 4'h4;
	localparam logic [3:0] ADDR_MODE_STS  = 4'h5;
	localparam logic [3:0] ADDR_INT_STS   = 4'h6;
	localparam logic [3:0] ADDR_INT_MASK  = 4'h7;
	localparam logic [3:0] ADDR_BOOT_STS  = 4'h8;
	localparam logic [3:0] ADDR_STRAP     = 4'h9;
	// Field positions
	localparam int SEL_A_BIT = 3;
	localparam int MODE2_LSB    = 4;
	// Reset values
	localparam logic [23:0] TRIM_RST = 24'h000000;
	localparam logic [1:0]  MASK_RST = 2'h0;
	// Loop mode codes
	localparam logic [3:0] MODE_AUTO     = 4'h0;
	localparam logic [3:0] MODE_FREERUN  = 4'h1;
	localparam logic [3:0] MODE_HOLDOVER = 4'h2;
	localparam logic [3:0] MODE_LOCKED   = 4'h4;
	localparam logic [3:0] MODE_PRELOCK2 = 4'h5;
	localparam logic [3:0] MODE_PRELOCK  = 4'h6;
	localparam logic [3:0] MODE_LOSTPH   = 4'h7;
	// Host interface select codes
	localparam logic [1:0] HOST_TWI_MASTER = 2'h3;
	// Oscillator frequency table in kHz, indexed by the 3-bit code
	localparam logic [15:0] OSC_KHZ [8] = '{16'd10000, 16'd12800,
		16'd13000, 16'd19440, 16'd20000, 16'd24576, 16'd25000,
		16'd30720};
	// Timing
	localparam int STRAP_HOLD_MS   = 2;
	// Milliseconds to microseconds, then cycles per microsecond
	localparam int STRAP_CYC       = STRAP_HOLD_MS * 1000 * CLK_MHZ;
	localparam int STABLE_NOLOAD_MS = 10;
	localparam int STABLE_LOAD_MS   = 100;
	localparam int NOLOAD_CYC = STABLE_NOLOAD_MS * 1000 * CLK_MHZ;
	localparam int LOAD_CYC   = STABLE_LOAD_MS * 1000 * CLK_MHZ;
	localparam int MAX_RETRY  = 2;
	localparam int TRIM_PPM_MAX = 741;
	typedef enum logic [2:0] {
		SLMRC_BOOT_STRAP, SLMRC_BOOT_LOAD, SLMRC_BOOT_WAIT,
		SLMRC_BOOT_SETTLE, SLMRC_BOOT_READY, SLMRC_BOOT_HALT
	} slmrc_boot_t;
	typedef enum logic [1:0] {
		SLMRC_AUTO_FREE, SLMRC_AUTO_PRE, SLMRC_AUTO_LOCK, SLMRC_AUTO_HOLD
	} slmrc_auto_t;
endpackage

// >>> core/slmrc_edge_sel.sv
// Module: selects the active edge of the system oscillator as a tick
`timescale 1ns/10ps
`default_nettype none
module slmrc_edge_sel
	import slmrc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic sys_osc_input,
	input  wire logic sel_a,
	output logic      tick_q
);
	logic s1_q, s2_q, s3_q;
	// Sync then detect the chosen edge; s1 feeds s2 only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			s1_q <= sys_osc_input;
			s2_q <= s1_q;
			s3_q <= s2_q;
			tick_q <= sel_a ? (s3_q & ~s2_q) : (~s3_q & s2_q); // [R7]
		end
	end
endmodule
`default_nettype wire

// >>> core/slmrc_loop_mode.sv
// Module: one loop's operating mode control, forced or automatic
`timescale 1ns/10ps
`default_nettype none
module slmrc_loop_mode
	import slmrc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] ctrl,
	input  wire logic       in_selected,
	input  wire logic       in_lock,
	input  wire logic       in_lost,
	output logic [3:0]      mode_q,
	output logic            change_q
);
	slmrc_auto_t auto_q;
	logic [3:0]  auto_mode, mode_d;
	// Automatic walk: free-run, pre-locked, locked, holdover
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_q <= SLMRC_AUTO_FREE;
		end else if (ctrl != MODE_AUTO) begin
			auto_q <= SLMRC_AUTO_FREE;
		end else begin
			case (auto_q)
			SLMRC_AUTO_FREE: if (in_selected) auto_q <= SLMRC_AUTO_PRE;
			SLMRC_AUTO_PRE: begin
				if (in_lost) auto_q <= SLMRC_AUTO_HOLD;
				else if (in_lock) auto_q <= SLMRC_AUTO_LOCK; // [R16]
			end
			SLMRC_AUTO_LOCK: if (in_lost) auto_q <= SLMRC_AUTO_HOLD;
			SLMRC_AUTO_HOLD: if (in_selected) auto_q <= SLMRC_AUTO_PRE;
			default: auto_q <= SLMRC_AUTO_FREE;
			endcase
		end
	end
	always_comb begin
		case (auto_q)
		SLMRC_AUTO_PRE:  auto_mode = MODE_PRELOCK;
		SLMRC_AUTO_LOCK: auto_mode = MODE_LOCKED;
		SLMRC_AUTO_HOLD: auto_mode = MODE_HOLDOVER;
		default:         auto_mode = MODE_FREERUN;
		endcase
	end
	// Forced codes override qualification; reserved codes keep the mode
	always_comb begin
		case (ctrl)
		MODE_AUTO:     mode_d = auto_mode;
		MODE_FREERUN, MODE_HOLDOVER, MODE_LOCKED, MODE_PRELOCK2,
		MODE_PRELOCK, MODE_LOSTPH: mode_d = ctrl; // [R11] [R17]
		default:       mode_d = mode_q;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= MODE_FREERUN;
			change_q <= 1'b0;
		end else begin
			mode_q <= mode_d; // [R12]
			change_q <= (mode_d != mode_q); // [R13]
		end
	end
	forced_hold_a: assert property (@(posedge clk) // [R17]
		disable iff (!rst_n)
		(ctrl == MODE_LOCKED && $past(ctrl) == MODE_LOCKED)
		|=> mode_q == MODE_LOCKED)
		else $error("forced mode not held");
	// The change pulse is launched on the same edge as the new mode
	change_pulse_a: assert property (@(posedge clk) // [R13]
		disable iff (!rst_n) (mode_q != $past(mode_q)) |-> change_q)
		else $error("mode change not flagged");
	auto_lock_a: assert property (@(posedge clk) // [R16]
		disable iff (!rst_n)
		(ctrl == MODE_AUTO && auto_q == SLMRC_AUTO_PRE && in_lock
		&& !in_lost) ##1 (ctrl == MODE_AUTO) |=> mode_q == MODE_LOCKED)
		else $error("auto lock not reached");
	cover_auto_lock: cover property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_LOCKED && ctrl == MODE_AUTO);
endmodule
`default_nettype wire

// >>> dv/slmrc_board_model.sv
// Board reset circuit and configuration memory loader facing the control block
`timescale 1ns/10ps
`default_nettype none
module slmrc_board_model #(
	parameter int RST_LOW_CYC = 3,
	parameter int LOAD_DLY    = 3
) (
	input  wire logic       clk,
	input  wire logic       rst_req,
	input  wire logic [2:0] freq_set,
	input  wire logic [1:0] host_set,
	input  wire logic       rate_set,
	input  wire logic [1:0] fail_set,
	input  wire logic       load_start_q,
	output logic            device_reset_low,
	output logic [2:0]      osc_freq_strap,
	output logic [1:0]      host_if_strap,
	output logic            line_rate_strap,
	output logic            load_done,
	output logic            load_fail,
	output logic [3:0]      start_cnt
);
	int         low_cnt;
	int         dly;
	logic [1:0] fails_left;
	// Power-up: reset already low while the oscillator runs
	initial begin
		low_cnt = RST_LOW_CYC;
		dly = 0;
		device_reset_low = 1'b0;
		{osc_freq_strap, host_if_strap, line_rate_strap} = 6'h00;
		{load_done, load_fail} = 2'h0;
		fails_left = 2'h0;
		start_cnt = 4'h0;
	end
	// Reset pulse shortened for the run; released on an edge only
	always @(posedge clk) begin
		if (rst_req) begin
			low_cnt <= RST_LOW_CYC;
			device_reset_low <= 1'b0;
		end else if (low_cnt > 0) begin
			low_cnt <= low_cnt - 1;
			device_reset_low <= 1'b0;
		end else begin
			device_reset_low <= 1'b1;
		end
	end
	// Straps track the settings under reset, then stay frozen
	// Loader answers each start late, failing as often as asked
	always @(posedge clk) begin
		load_done <= 1'b0;
		load_fail <= 1'b0;
		if (!device_reset_low) begin
			osc_freq_strap <= freq_set;
			host_if_strap <= host_set;
			line_rate_strap <= rate_set;
			fails_left <= fail_set;
			start_cnt <= 4'h0;
			dly <= 0;
		end else if (load_start_q) begin
			dly <= LOAD_DLY;
			start_cnt <= start_cnt + 4'h1;
		end else if (dly > 1) begin
			dly <= dly - 1;
		end else if (dly == 1) begin
			dly <= 0;
			if (fails_left != 2'h0) begin
				load_fail <= 1'b1;
				fails_left <= fails_left - 2'h1;
			end else begin
				load_done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/sync_loop_mode_reset_ctrl_bench.sv
// Testbench: boot, oscillator setup, loop modes and mode-change interrupt
`timescale 1ns/10ps
`default_nettype none
module sync_loop_mode_reset_ctrl_bench
	import slmrc_pkg::*;
;
	localparam int SP = 8;
	localparam int NP = 40;
	localparam int LP = 30;
	logic        clk, rst_req, rate_set, osc, reg_wr, reg_rd;
	logic [2:0]  freq_set, osc_freq_strap;
	logic [1:0]  host_set, fail_set, host_if_strap, sel, lck, lst;
	logic        device_reset_low, line_rate_strap, load_done, load_fail;
	logic [3:0]  start_cnt, reg_addr, l1_mode_q, l2_mode_q;
	logic [31:0] reg_wdata, reg_rdata_q, rd;
	logic        load_start_q, clocks_stable_q, halted_q, osc_tick_q, irq_q;
	logic [15:0] osc_khz_q;
	logic [23:0] trim_q;
	int          err_count, checked, t;
	// Nominal oscillator rates in kHz, by code
	logic [15:0] khz [8] = '{16'h2710, 16'h3200, 16'h32c8, 16'h4bf0,
		16'h4e20, 16'h6000, 16'h61a8, 16'h7800};
	slmrc_board_model board (.clk(clk), .rst_req(rst_req),
		.freq_set(freq_set), .host_set(host_set), .rate_set(rate_set),
		.fail_set(fail_set), .load_start_q(load_start_q),
		.device_reset_low(device_reset_low),
		.osc_freq_strap(osc_freq_strap), .host_if_strap(host_if_strap),
		.line_rate_strap(line_rate_strap), .load_done(load_done),
		.load_fail(load_fail), .start_cnt(start_cnt));
	slmrc_top #(.STRAP_CYCLES(SP), .NOLOAD_CYCLES(NP), .LOAD_CYCLES(LP)) dut (
		.clk(clk), .device_reset_low(device_reset_low),
		.sys_osc_input(osc), .osc_freq_strap(osc_freq_strap),
		.host_if_strap(host_if_strap), .line_rate_strap(line_rate_strap),
		.load_done(load_done), .load_fail(load_fail),
		.l1_selected(sel[0]), .l1_lock(lck[0]), .l1_lost(lst[0]),
		.l2_selected(sel[1]), .l2_lock(lck[1]), .l2_lost(lst[1]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.load_start_q(load_start_q), .clocks_stable_q(clocks_stable_q),
		.halted_q(halted_q), .osc_tick_q(osc_tick_q), .osc_khz_q(osc_khz_q),
		.trim_q(trim_q), .l1_mode_q(l1_mode_q), .l2_mode_q(l2_mode_q),
		.irq_q(irq_q));
	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rdr(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata_q;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Restart the device with given straps; bounded wait for boot end
	task automatic boot(input logic [1:0] h, input logic [1:0] f);
		@(posedge clk);
		host_set <= h;
		fail_set <= f;
		rst_req <= 1'b1;
		@(posedge clk);
		rst_req <= 1'b0;
		// Let the reset land first, or the old stable flag ends the wait
		@(posedge clk);
		t = 0;
		while (clocks_stable_q !== 1'b1 && halted_q !== 1'b1 && t < 400) begin
			@(posedge clk);
			t++;
		end
		#1;
	endtask
	task automatic mode_is(input int n, input logic [3:0] m);
		rdr(ADDR_MODE_STS);
		check("mode status", rd[4*n+:4], m);
		check("mode pins", n ? l2_mode_q : l1_mode_q, m);
	endtask
	task automatic flag_is(input int n, input logic v);
		rdr(ADDR_INT_STS);
		check("change flag", rd[n], v);
	endtask
	// Memory load with 0 to 3 failures; the third halts
	task automatic t_load;
		for (int f = 0; f < 4; f++) begin
			boot(2'h3, 2'(f));
			check("halted", halted_q, f == 3);
			check("stable", clocks_stable_q, f < 3);
			check("attempts", start_cnt, f < 3 ? f + 1 : 3);
			if (f < 3) check("load time", t <= (f+1)*LP+SP+16, 1);
			rdr(ADDR_BOOT_STS);
			check("boot sts", rd, f < 3 ? 32'h3 | (f << 3) : 32'h15);
			rdr(ADDR_HOST_IF);
			check("host if", rd, 32'h3);
		end
	endtask
	// Plain boots for each other host strap, then reset values
	task automatic t_plain;
		for (int h = 0; h < 3; h++) begin
			boot(2'(h), 2'h0);
			check("stable", clocks_stable_q, 1'b1);
			check("boot time", t <= NP + 12, 1);
			check("attempts", start_cnt, 0);
			rdr(ADDR_HOST_IF);
			check("host if", rd, h);
		end
		rdr(ADDR_OSC_CFG);
		check("osc code", rd[2:0], 3'h5);
		check("osc khz", osc_khz_q, khz[5]);
		rdr(ADDR_INT_MASK);
		check("mask reset", rd, 32'h0);
		rdr(ADDR_MODE_STS);
		check("mode reset", rd, 32'h11);
		rdr(4'hf);
		check("unmapped", rd, 32'h0);
		rdr(ADDR_STRAP);
		check("line rate", rd, 32'h1);
		wr(ADDR_HOST_IF, 32'h1);
		rdr(ADDR_HOST_IF);
		check("host if wr", rd, 32'h1);
	endtask
	// Every frequency code and the trim word
	task automatic t_osc;
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_OSC_CFG, 32'(i));
			tick(3);
			check("osc khz", osc_khz_q, khz[i]);
			rdr(ADDR_OSC_CFG);
			check("osc cfg", rd, i);
		end
		wr(ADDR_TRIM, 32'h00a5c35a);
		rdr(ADDR_TRIM);
		check("trim reg", rd, 32'h00a5c35a);
		check("trim pins", trim_q, 24'ha5c35a);
	endtask
	task automatic ticks(input logic v, output int n);
		@(posedge clk);
		osc <= v;
		n = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (osc_tick_q === 1'b1) n++;
		end
	endtask
	// Only the selected oscillator edge makes a tick
	task automatic t_edge;
		int n;
		for (int e = 0; e < 2; e++) begin
			wr(ADDR_OSC_CFG, 32'(e) << SEL_A_BIT);
			ticks(e[0], n);
			ticks(~e[0], n);
			check("active edge", n, 1);
			ticks(e[0], n);
			check("other edge", n, 0);
		end
	endtask
	// Automatic mode: selected, then lock, then lost
	task automatic t_auto(input int n);
		@(posedge clk);
		sel[n] <= 1'b1;
		tick(6);
		mode_is(n, MODE_PRELOCK);
		flag_is(n, 1'b1);
		wr(ADDR_INT_STS, 32'h3);
		@(posedge clk);
		lck[n] <= 1'b1;
		tick(6);
		mode_is(n, MODE_LOCKED);
		flag_is(n, 1'b1);
		@(posedge clk);
		sel[n] <= 1'b0;
		lst[n] <= 1'b1;
		tick(6);
		mode_is(n, MODE_HOLDOVER);
	endtask
	// Forced codes, reserved codes, and interrupt masking
	task automatic t_forced(input int n);
		// Starts away from holdover, where the automatic run left the loop
		logic [3:0] c [6] = '{4'h4, 4'h2, 4'h5, 4'h6, 4'h7, 4'h1};
		logic [3:0] r [3] = '{4'h3, 4'h8, 4'hf};
		wr(ADDR_INT_MASK, 32'h3);
		foreach (c[i]) begin
			wr(ADDR_INT_STS, 32'h3);
			wr(ADDR_L1_CTRL + 4'(n), 32'(c[i]));
			tick(5);
			mode_is(n, c[i]);
			flag_is(n, 1'b1);
			check("irq", irq_q, 1'b1);
		end
		wr(ADDR_INT_STS, 32'h3);
		@(posedge clk);
		sel[n] <= ~sel[n];
		lck[n] <= ~lck[n];
		lst[n] <= ~lst[n];
		tick(6);
		mode_is(n, MODE_FREERUN);
		flag_is(n, 1'b0);
		foreach (r[i]) begin
			wr(ADDR_L1_CTRL + 4'(n), 32'(r[i]));
			tick(5);
			mode_is(n, MODE_FREERUN);
			flag_is(n, 1'b0);
		end
		wr(ADDR_L1_CTRL + 4'(n), 32'(MODE_HOLDOVER));
		tick(5);
		wr(ADDR_INT_MASK, 32'h0);
		tick(3);
		check("irq masked", irq_q, 1'b0);
		flag_is(n, 1'b1);
		wr(ADDR_INT_MASK, 32'h1 << n);
		tick(3);
		check("irq unmasked", irq_q, 1'b1);
		wr(ADDR_INT_STS, 32'h1 << n);
		tick(3);
		flag_is(n, 1'b0);
		check("irq cleared", irq_q, 1'b0);
		@(posedge clk);
		{sel[n], lck[n], lst[n]} <= 3'h0;
	endtask
	task automatic end_of_test;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence
	initial begin
		{rst_req, rate_set, osc, reg_wr, reg_rd} = 5'h08;
		{freq_set, host_set, fail_set} = 7'h50;
		{sel, lck, lst, reg_addr} = 10'h000;
		reg_wdata = 32'h0;
		err_count = 0;
		checked = 0;
		t_load();
		t_plain();
		t_osc();
		t_edge();
		t_auto(0);
		t_auto(1);
		t_forced(0);
		t_forced(1);
		end_of_test();
	end
	// Watchdog well above the roughly one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
